// ==== hdl/machine_status_csr_regs.svh ====
`ifndef MACHINE_STATUS_CSR_REGS_SVH
`define MACHINE_STATUS_CSR_REGS_SVH
`define TABLE_JUMP_BASE_ADDR   12'h017
`define MACHINE_STATUS_ADDR    12'h300
`define MACHINE_ISA_REPORT_ADDR 12'h301
`define MACHINE_STATUS_RESET   32'h0000_1800
`define TABLE_JUMP_BASE_RESET  32'h0000_0000
`define TJB_BASE_MASK          32'hffff_ffc0
`define MS_MIE_BIT             3
`define MS_PRIOR_INTERRUPT_ENABLE_BIT            7
`define MS_MPP_LO              11
`define MS_MPP_HI              12
`define MS_MODIFY_PRIVILEGE_BIT_BIT            17
`define MS_TW_BIT              21
`define ISA_WIDTH_VAL          2'h1
`define ISA_C_BIT              2
`define ISA_E_BIT              4
`define ISA_I_BIT              8
`define ISA_M_BIT              12
`define ISA_U_BIT              20
`define ISA_X_BIT              23
`endif

// ==== hdl/machine_status_csr_pkg.sv ====
package machine_status_csr_pkg;
  typedef enum logic [1:0] {
    PRIV_USER    = 2'b00,
    PRIV_MACHINE = 2'b11
  } priv_t;

  typedef enum logic [1:0] {
    CSR_OP_WRITE = 2'b01,
    CSR_OP_SET   = 2'b10,
    CSR_OP_CLEAR = 2'b11
  } csr_op_t;

  typedef struct packed {
    logic        en;
    csr_op_t     op;
    logic [11:0] addr;
    logic [31:0] wdata;
  } csr_req_t;
endpackage

// ==== hdl/machine_status_csr_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "machine_status_csr_regs.svh"

module machine_status_csr_bank #(
  parameter bit TABLE_JUMP_OPTION      = 1'b1,
  parameter bit MULTIPLY_DIVIDE_OPTION = 1'b1,
  parameter bit EMBEDDED_BASE          = 1'b0
) (
  input  wire logic                              sys_clk,
  input  wire logic                              rst,
  input  wire machine_status_csr_pkg::csr_req_t  csr_req,
  output logic [31:0]                            csr_rdata,
  output logic                                   csr_addr_hit,
  input  wire logic                              trap_take,
  input  wire logic                              trap_return,
  input  wire logic                              wfi_exec,
  output machine_status_csr_pkg::priv_t          cur_priv,
  output machine_status_csr_pkg::priv_t          data_priv,
  output logic                                   wfi_illegal,
  output logic                                   irq_global_en
);

  logic [31:0] status_q;
  logic [31:0] status_d;
  logic [31:0] tjb_q;
  logic [31:0] tjb_d;
  logic [1:0]  priv_q;
  logic [1:0]  priv_d;

  function automatic logic [31:0] apply_op(input logic [1:0] op, input logic [31:0] old,
                                           input logic [31:0] wd);
    case (op)
      2'b01:   apply_op = wd;
      2'b10:   apply_op = old | wd;
      2'b11:   apply_op = old & ~wd;
      default: apply_op = old;
    endcase
  endfunction

  // Only user and machine are legal; anything else falls to user
  function automatic logic [1:0] legal_priv(input logic [1:0] p);
    legal_priv = (p == 2'h3) ? 2'h3 : 2'h0;
  endfunction

  wire hit_tjb    = (csr_req.addr == `TABLE_JUMP_BASE_ADDR) && TABLE_JUMP_OPTION;
  wire hit_status = (csr_req.addr == `MACHINE_STATUS_ADDR);
  wire hit_isa    = (csr_req.addr == `MACHINE_ISA_REPORT_ADDR);
  wire wr_tjb     = csr_req.en && hit_tjb;
  wire wr_status  = csr_req.en && hit_status;
  wire [31:0] status_new = apply_op(csr_req.op, status_q, csr_req.wdata);
  wire [31:0] tjb_new    = apply_op(csr_req.op, tjb_q, csr_req.wdata);

  // Access legality is left to the decoder; the bank only flags address presence
  assign csr_addr_hit = hit_tjb | hit_status | hit_isa;

  wire [31:0] isa_value = {`ISA_WIDTH_VAL, 30'h0000_0000}
                        | (32'h1 << `ISA_C_BIT)
                        | (32'h1 << `ISA_U_BIT)
                        | (32'h1 << `ISA_X_BIT)
                        | ({31'h0, ~EMBEDDED_BASE} << `ISA_I_BIT)
                        | ({31'h0, EMBEDDED_BASE} << `ISA_E_BIT)
                        | ({31'h0, MULTIPLY_DIVIDE_OPTION} << `ISA_M_BIT);

  always_comb begin
    status_d = status_q;
    if (wr_status) begin
      status_d = 32'h0000_0000;
      status_d[`MS_MIE_BIT]  = status_new[`MS_MIE_BIT];
      status_d[`MS_PRIOR_INTERRUPT_ENABLE_BIT] = status_new[`MS_PRIOR_INTERRUPT_ENABLE_BIT];
      status_d[`MS_MODIFY_PRIVILEGE_BIT_BIT] = status_new[`MS_MODIFY_PRIVILEGE_BIT_BIT];
      status_d[`MS_TW_BIT]   = status_new[`MS_TW_BIT];
      status_d[`MS_MPP_HI:`MS_MPP_LO] = legal_priv(status_new[`MS_MPP_HI:`MS_MPP_LO]);
    end
    // Core events win over a coincident software write
    if (trap_take) begin
      status_d[`MS_PRIOR_INTERRUPT_ENABLE_BIT] = status_q[`MS_MIE_BIT];
      status_d[`MS_MIE_BIT]  = 1'b0;
      status_d[`MS_MPP_HI:`MS_MPP_LO] = priv_q;
    end else if (trap_return) begin
      status_d[`MS_MIE_BIT]  = status_q[`MS_PRIOR_INTERRUPT_ENABLE_BIT];
      status_d[`MS_PRIOR_INTERRUPT_ENABLE_BIT] = 1'b1;
      status_d[`MS_MPP_HI:`MS_MPP_LO] = 2'h0;
    end
  end

  always_comb begin
    priv_d = priv_q;
    if (trap_take) begin
      priv_d = 2'h3;
    end else if (trap_return) begin
      priv_d = status_q[`MS_MPP_HI:`MS_MPP_LO];
    end
  end

  assign tjb_d = wr_tjb ? (tjb_new & `TJB_BASE_MASK) : tjb_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_q <= `MACHINE_STATUS_RESET;
      tjb_q    <= `TABLE_JUMP_BASE_RESET;
      priv_q   <= 2'h3;
    end else begin
      status_q <= status_d;
      tjb_q    <= tjb_d;
      priv_q   <= priv_d;
    end
  end

  // ISA register has no storage, so writes cannot reach it
  assign csr_rdata = hit_status ? status_q :
                     hit_isa    ? isa_value :
                     hit_tjb    ? tjb_q : 32'h0000_0000;

  assign cur_priv      = machine_status_csr_pkg::priv_t'(priv_q);
  assign data_priv     = status_q[`MS_MODIFY_PRIVILEGE_BIT_BIT] ?
                         machine_status_csr_pkg::priv_t'(status_q[`MS_MPP_HI:`MS_MPP_LO]) :
                         machine_status_csr_pkg::priv_t'(priv_q);
  // Zero time limit: the fault is raised in the same cycle as the wait
  assign wfi_illegal   = wfi_exec && status_q[`MS_TW_BIT] && (priv_q == 2'h0);
  assign irq_global_en = status_q[`MS_MIE_BIT];

  a_mpp_legal: assert property (@(posedge sys_clk) disable iff (rst)
    status_q[12:11] == 2'h0 || status_q[12:11] == 2'h3)
    else $error("previous privilege holds illegal value");
  a_status_zero: assert property (@(posedge sys_clk) disable iff (rst)
    (status_q & 32'hffdd_e777) == 32'h0)
    else $error("hardwired status bit nonzero");
  a_reset_value: assert property (@(posedge sys_clk)
    rst |=> status_q == 32'h0000_1800 && priv_q == 2'h3)
    else $error("status reset value wrong");
  a_mret_priv: assert property (@(posedge sys_clk) disable iff (rst)
    trap_return && !trap_take |=> priv_q == $past(status_q[12:11]))
    else $error("trap return privilege wrong");
  a_trap_stack: assert property (@(posedge sys_clk) disable iff (rst)
    trap_take |=> status_q[7] == $past(status_q[3]) && !status_q[3])
    else $error("interrupt enable not stacked");
  a_mret_restore: assert property (@(posedge sys_clk) disable iff (rst)
    trap_return && !trap_take |=> status_q[3] == $past(status_q[7]))
    else $error("interrupt enable not restored");
  a_mie_write: assert property (@(posedge sys_clk) disable iff (rst)
    csr_req.en && hit_status && csr_req.op == machine_status_csr_pkg::CSR_OP_WRITE
    && !trap_take && !trap_return |=> status_q[3] == $past(csr_req.wdata[3]))
    else $error("interrupt enable write lost");
  a_tjb_mode: assert property (@(posedge sys_clk) disable iff (rst)
    tjb_q[5:0] == 6'h0)
    else $error("table jump mode bits nonzero");
  a_data_priv: assert property (@(posedge sys_clk) disable iff (rst)
    status_q[17] |-> data_priv == status_q[12:11])
    else $error("data privilege not previous privilege");
  a_wfi_trap: assert property (@(posedge sys_clk) disable iff (rst)
    wfi_exec && status_q[21] && priv_q == 2'h0 |-> wfi_illegal)
    else $error("user wait not trapped");
  a_isa_const: assert property (@(posedge sys_clk) disable iff (rst)
    hit_isa |-> csr_rdata[31:30] == 2'h1 && csr_rdata[2] && csr_rdata[20] && csr_rdata[23])
    else $error("isa value wrong");

  // Core events are excluded here, since they override the stacking fields
  sequence s_quiet;
    !trap_take && !trap_return;
  endsequence

  sequence s_status_write;
    csr_req.en && hit_status && csr_req.op == machine_status_csr_pkg::CSR_OP_WRITE ##0 s_quiet;
  endsequence

  sequence s_status_set;
    csr_req.en && hit_status && csr_req.op == machine_status_csr_pkg::CSR_OP_SET ##0 s_quiet;
  endsequence

  sequence s_status_clear;
    csr_req.en && hit_status && csr_req.op == machine_status_csr_pkg::CSR_OP_CLEAR ##0 s_quiet;
  endsequence

  sequence s_ret_only;
    trap_return && !trap_take;
  endsequence

  a_trap_priv: assert property (@(posedge sys_clk) disable iff (rst)
    trap_take |=> priv_q == 2'h3)
    else $error("trap did not enter machine mode");

  a_trap_mpp: assert property (@(posedge sys_clk) disable iff (rst)
    trap_take |=> status_q[12:11] == $past(priv_q))
    else $error("trap did not save privilege");

  a_ret_prior_interrupt_enable: assert property (@(posedge sys_clk) disable iff (rst)
    s_ret_only |=> status_q[7])
    else $error("trap return did not set prior enable");

  a_ret_mpp: assert property (@(posedge sys_clk) disable iff (rst)
    s_ret_only |=> status_q[12:11] == 2'h0)
    else $error("trap return did not clear previous privilege");

  a_mpp_machine: assert property (@(posedge sys_clk) disable iff (rst)
    s_status_write ##0 csr_req.wdata[12:11] == 2'h3 |=> status_q[12:11] == 2'h3)
    else $error("machine previous privilege not stored");

  a_mpp_default: assert property (@(posedge sys_clk) disable iff (rst)
    s_status_write ##0 (csr_req.wdata[12:11] != 2'h3) |=> status_q[12:11] == 2'h0)
    else $error("unsupported previous privilege not defaulted");

  a_modify_privilege_bit_write: assert property (@(posedge sys_clk) disable iff (rst)
    s_status_write |=> status_q[17] == $past(csr_req.wdata[17]))
    else $error("modify privilege write lost");

  a_tw_write: assert property (@(posedge sys_clk) disable iff (rst)
    s_status_write |=> status_q[21] == $past(csr_req.wdata[21]))
    else $error("timeout wait write lost");

  a_prior_interrupt_enable_write: assert property (@(posedge sys_clk) disable iff (rst)
    s_status_write |=> status_q[7] == $past(csr_req.wdata[7]))
    else $error("prior enable write lost");

  a_mie_set: assert property (@(posedge sys_clk) disable iff (rst)
    s_status_set |=> status_q[3] == ($past(status_q[3]) | $past(csr_req.wdata[3])))
    else $error("interrupt enable set wrong");

  a_mie_clear: assert property (@(posedge sys_clk) disable iff (rst)
    s_status_clear |=> status_q[3] == ($past(status_q[3]) & ~$past(csr_req.wdata[3])))
    else $error("interrupt enable clear wrong");

  a_status_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !(csr_req.en && hit_status) ##0 s_quiet |=> $stable(status_q))
    else $error("status changed without cause");

  a_noop_hold: assert property (@(posedge sys_clk) disable iff (rst)
    csr_req.en && csr_req.op == 2'h0 ##0 s_quiet |=> $stable(status_q))
    else $error("empty operation changed status");

  a_tjb_write: assert property (@(posedge sys_clk) disable iff (rst)
    wr_tjb && csr_req.op == machine_status_csr_pkg::CSR_OP_WRITE
    |=> tjb_q == ($past(csr_req.wdata) & 32'hffff_ffc0))
    else $error("table jump base write wrong");

  a_tjb_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !wr_tjb |=> $stable(tjb_q))
    else $error("table jump base changed without write");

  a_tjb_reset: assert property (@(posedge sys_clk)
    rst |=> tjb_q == 32'h0000_0000)
    else $error("table jump base reset wrong");

  a_tjb_present: assert property (@(posedge sys_clk) disable iff (rst)
    csr_req.addr == 12'h017 |-> csr_addr_hit == TABLE_JUMP_OPTION)
    else $error("table jump presence wrong");

  a_isa_zero: assert property (@(posedge sys_clk) disable iff (rst)
    hit_isa |-> (csr_rdata & 32'h3f6f_eeeb) == 32'h0000_0000)
    else $error("isa reserved bit set");

  a_isa_opts: assert property (@(posedge sys_clk) disable iff (rst)
    hit_isa |-> csr_rdata[12] == MULTIPLY_DIVIDE_OPTION && csr_rdata[8] == !EMBEDDED_BASE
    && csr_rdata[4] == EMBEDDED_BASE)
    else $error("isa option bits wrong");

  a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (rst)
    !csr_addr_hit |-> csr_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_status_read: assert property (@(posedge sys_clk) disable iff (rst)
    hit_status |-> csr_rdata == status_q)
    else $error("status read wrong");

  a_wfi_only: assert property (@(posedge sys_clk) disable iff (rst)
    wfi_illegal |-> wfi_exec && status_q[21] && priv_q == 2'h0)
    else $error("wait flagged without cause");

  a_data_own: assert property (@(posedge sys_clk) disable iff (rst)
    !status_q[17] |-> data_priv == priv_q)
    else $error("data privilege not current privilege");

  a_take_wins: assert property (@(posedge sys_clk) disable iff (rst)
    trap_take && trap_return |=> priv_q == 2'h3 && !status_q[3])
    else $error("trap entry did not win");

  a_event_write: assert property (@(posedge sys_clk) disable iff (rst)
    trap_take && csr_req.en && hit_status |=> !status_q[3])
    else $error("write overrode trap entry");

  a_priv_legal: assert property (@(posedge sys_clk) disable iff (rst)
    priv_q == 2'h0 || priv_q == 2'h3)
    else $error("privilege holds illegal value");

  a_priv_hold: assert property (@(posedge sys_clk) disable iff (rst)
    s_quiet |=> $stable(priv_q))
    else $error("privilege changed without event");

  a_irq_en: assert property (@(posedge sys_clk) disable iff (rst)
    s_status_write |=> irq_global_en == $past(csr_req.wdata[3]))
    else $error("global enable output wrong");

endmodule
`default_nettype wire

// ==== bench/machine_status_csr_bank_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module machine_status_csr_bank_tb;
  logic                             sys_clk = 1'b0;
  logic                             rst = 1'b1;
  machine_status_csr_pkg::csr_req_t csr_req = '0;
  logic                             trap_take = 1'b0;
  logic                             trap_return = 1'b0;
  logic                             wfi_exec = 1'b0;
  logic [31:0]                      csr_rdata;
  logic                             csr_addr_hit;
  machine_status_csr_pkg::priv_t    cur_priv;
  machine_status_csr_pkg::priv_t    data_priv;
  logic                             wfi_illegal;
  logic                             irq_global_en;
  integer                           miscompares = 0;
  integer                           checks = 0;
  integer                           seed = 73950;
  logic [31:0]                      w;
  logic [31:0]                      e;

  always #2.5 sys_clk = ~sys_clk;

  machine_status_csr_bank machine_status_csr_bank_i (.sys_clk(sys_clk), .rst(rst),
    .csr_req(csr_req), .csr_rdata(csr_rdata), .csr_addr_hit(csr_addr_hit),
    .trap_take(trap_take), .trap_return(trap_return), .wfi_exec(wfi_exec),
    .cur_priv(cur_priv), .data_priv(data_priv), .wfi_illegal(wfi_illegal),
    .irq_global_en(irq_global_en));

  // Only MIE, PRIOR_INTERRUPT_ENABLE, PREVIOUS_PRIVILEGE_FIELD, MODIFY_PRIVILEGE_BIT and TW survive; reserved privilege codes fall back to user
  function automatic logic [31:0] legal_status(input logic [31:0] v);
    logic [31:0] r;
    r = v & 32'h0022_1888;
    if (r[12:11] == 2'h1 || r[12:11] == 2'h2) r[12:11] = 2'h0;
    return r;
  endfunction

  function automatic logic [31:0] isa_value(input logic emb, input logic mul);
    return {2'h1, 6'h0, 1'b1, 2'h0, 1'b1, 7'h0, mul, 3'h0, ~emb, 3'h0, emb, 1'b0, 1'b1, 2'h0};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input machine_status_csr_pkg::csr_op_t o = machine_status_csr_pkg::CSR_OP_WRITE);
    @(posedge sys_clk);
    csr_req <= '{en: 1'b1, op: o, addr: a, wdata: d};
    @(posedge sys_clk);
    csr_req.en <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge sys_clk);
    csr_req.addr <= a;
    #1;
  endtask

  // Kind 0 takes a trap, 1 returns, 2 executes a wait; the illegal flag is combinational
  task automatic pulse(input int k, input logic ill);
    @(posedge sys_clk);
    trap_take <= (k == 0);
    trap_return <= (k == 1);
    wfi_exec <= (k == 2);
    #1;
    chk({31'h0, wfi_illegal}, {31'h0, ill});
    @(posedge sys_clk);
    trap_take <= 1'b0;
    trap_return <= 1'b0;
    wfi_exec <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rd(12'h300);
    chk(csr_rdata, 32'h0000_1800);
    chk({30'h0, cur_priv}, 32'h3);
    rd(12'h017);
    chk(csr_rdata, 32'h0);
    wr(12'h301, 32'h0);
    rd(12'h301);
    chk(csr_rdata, isa_value(1'b0, 1'b1));
    rd(12'h123);
    chk({csr_rdata[30:0], csr_addr_hit}, 32'h0);
    $display("reset and constant test done");
    for (int i = 0; i < 40; i++) begin
      w = $random(seed);
      // Both reserved privilege codes and all ones come first
      if (i < 3) w = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0000_0800 : 32'h0000_1000;
      e = legal_status(w);
      wr(12'h300, w);
      rd(12'h300);
      chk(csr_rdata, e);
      chk({31'h0, irq_global_en}, {31'h0, w[3]});
      chk({30'h0, data_priv}, e[17] ? {30'h0, e[12:11]} : 32'h3);
      wr(12'h017, w);
      rd(12'h017);
      chk(csr_rdata, w & 32'hffff_ffc0);
    end
    $display("random write test done");
    wr(12'h300, 32'h0000_0008);
    pulse(1, 1'b0);
    rd(12'h300);
    chk(csr_rdata, 32'h0000_0080);
    chk({30'h0, cur_priv}, 32'h0);
    wr(12'h300, 32'h0022_1888);
    rd(12'h300);
    chk({30'h0, data_priv}, 32'h3);
    pulse(2, 1'b1);
    wr(12'h300, 32'h0000_0008);
    pulse(2, 1'b0);
    pulse(0, 1'b0);
    rd(12'h300);
    chk(csr_rdata, 32'h0000_0080);
    chk({30'h0, cur_priv}, 32'h3);
    pulse(1, 1'b0);
    rd(12'h300);
    chk(csr_rdata, 32'h0000_0088);
    chk({30'h0, cur_priv}, 32'h0);
    $display("trap test done");
    // Software keeps what it read and changes one field only
    rd(12'h300);
    w = csr_rdata | 32'h0002_0000;
    wr(12'h300, w);
    rd(12'h300);
    chk(csr_rdata, legal_status(w));
    chk({30'h0, data_priv}, 32'h0);
    wr(12'h300, 32'h0020_0000, machine_status_csr_pkg::CSR_OP_SET);
    rd(12'h300);
    chk(csr_rdata, 32'h0022_0088);
    wr(12'h300, 32'h0000_0008, machine_status_csr_pkg::CSR_OP_CLEAR);
    rd(12'h300);
    chk(csr_rdata, 32'h0022_0080);
    chk({31'h0, irq_global_en}, 32'h0);
    $display("set and clear test done");
    end_of_test();
  end

  // Whole sequence needs well under 2,000 cycles
  initial begin
    #50000;
    miscompares++;
    end_of_test();
  end
endmodule
`default_nettype wire
